// ---- rtl/psb_pkg.sv ----
// package of the parallel slave byte port: register map and field layout
// assumes a 32-bit classic wishbone slave with word-aligned registers
`default_nettype none
package psb_pkg;
    localparam int          PSB_AW          = 4;
    localparam logic [3:0]  PSB_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  PSB_ADDR_DATA   = 4'h4;
    localparam logic [3:0]  PSB_ADDR_FLAG   = 4'h8;
    localparam logic [3:0]  PSB_ADDR_ENABLE = 4'hC;
    localparam int          PSB_DW          = 8;
    localparam int          PSB_IBF_BIT     = 7;
    localparam int          PSB_OBF_BIT     = 6;
    localparam int          PSB_INPUT_OVERFLOW_FLAG_BIT    = 5;
    localparam int          PSB_MODE_BIT    = 4;
    localparam int          PSB_IRQ_BIT     = 7;
    localparam int          PSB_PRIO_BIT    = 6;
    localparam logic [7:0]  PSB_BYTE_ZERO   = 8'h00;
    localparam logic [31:0] PSB_WORD_ZERO   = 32'h0000_0000;
    localparam logic [2:0]  PSB_SYNC_IDLE   = 3'h7;
    localparam logic        PSB_HI          = 1'b1;
    localparam logic        PSB_LO          = 1'b0;
endpackage
`default_nettype wire

// ---- rtl/psb_port.sv ----
// parallel slave byte port: external strobe bus plus wishbone register file
// assumes strobes and data pins are asynchronous to i_mclk
`default_nettype none

// Functional notes
// - mode bit set turns port into slave
// - mode clear: strobes ignored, plain gpio
// - external accesses asynchronous, sampled by strobes
// - write ends on cs or wr high, captures
// - write end sets input full and irq
// - input full flag is read only
// - write over unread byte sets sticky overflow
// - cs and rd low drive output latch
// - read end releases pins, sets irq
// - output full set until external read
// - cpu write during read: no output full
// - control low nibble zero, reset zero
// - irq flag top bit, enable, priority bits
module psb_port
    import psb_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_reset_n,
    input  wire logic          i_wb_cyc,
    input  wire logic          i_wb_stb,
    input  wire logic          i_wb_we,
    input  wire logic [3:0]    i_wb_adr,
    input  wire logic [3:0]    i_wb_sel,
    input  wire logic [31:0]   i_wb_dat,
    output logic      [31:0]   o_wb_dat,
    output logic               o_wb_ack,
    input  wire logic          i_read_strobe_pin_n,
    input  wire logic          i_write_strobe_pin_n,
    input  wire logic          i_chip_select_pin_n,
    input  wire logic [7:0]    i_byte_port_data,
    output logic      [7:0]    o_byte_port_data,
    output logic               o_byte_port_oe_n,
    output logic               o_slave_mode_select,
    output logic               o_irq,
    output logic               o_irq_priority
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0]  rd_sync;
        logic [2:0]  wr_sync;
        logic [2:0]  cs_sync;
        logic [7:0]  din_sync1;
        logic [7:0]  din_sync2;
        logic [7:0]  din_sync3;
        logic        wr_active;
        logic        rd_active;
        logic        mode;
        logic        input_full_flag;
        logic        output_full_flag;
        logic        input_overflow_flag;
        logic [7:0]  in_latch;
        logic [7:0]  out_latch;
        logic        irq_flag;
        logic        irq_en;
        logic        irq_prio;
        logic [31:0] rdata;
        logic        ack;
        logic [7:0]  pin_out;
        logic        pin_oe_n;
        logic        irq_out;
    } psb_state_t;

    psb_state_t state_reg;
    psb_state_t state_next;

    logic wr_low;
    logic rd_low;
    logic cs_low;
    logic wr_high;
    logic rd_high;
    logic cs_high;
    logic acc;
    logic wb_wr;
    logic wb_rd;
    logic wr_end;
    logic rd_end;

    // only stages two and three feed decisions; stage one is metastable
    always_comb begin
        wr_low = (state_reg.wr_sync[1] == PSB_LO)
            && (state_reg.wr_sync[2] == PSB_LO);
        rd_low = (state_reg.rd_sync[1] == PSB_LO)
            && (state_reg.rd_sync[2] == PSB_LO);
        cs_low = (state_reg.cs_sync[1] == PSB_LO)
            && (state_reg.cs_sync[2] == PSB_LO);
        wr_high = (state_reg.wr_sync[1] == PSB_HI)
            && (state_reg.wr_sync[2] == PSB_HI);
        rd_high = (state_reg.rd_sync[1] == PSB_HI)
            && (state_reg.rd_sync[2] == PSB_HI);
        cs_high = (state_reg.cs_sync[1] == PSB_HI)
            && (state_reg.cs_sync[2] == PSB_HI);
        acc    = i_wb_cyc && i_wb_stb && !state_reg.ack;
        wb_wr  = acc && i_wb_we && i_wb_sel[0];
        wb_rd  = acc && !i_wb_we;
        wr_end = state_reg.wr_active && (cs_high || wr_high);
        rd_end = state_reg.rd_active && (cs_high || rd_high);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        state_next.rd_sync = {state_reg.rd_sync[1:0], i_read_strobe_pin_n};
        state_next.wr_sync = {state_reg.wr_sync[1:0], i_write_strobe_pin_n};
        state_next.cs_sync = {state_reg.cs_sync[1:0], i_chip_select_pin_n};
        state_next.din_sync1 = i_byte_port_data;
        state_next.din_sync2 = state_reg.din_sync1;
        state_next.din_sync3 = state_reg.din_sync2;
        state_next.ack = acc;

        // bus side first so hardware set events below win over clears
        if (wb_wr) begin
            if (i_wb_adr == PSB_ADDR_CTRL) begin
                state_next.mode = i_wb_dat[PSB_MODE_BIT];
                // overflow is clear-only from software
                if (!i_wb_dat[PSB_INPUT_OVERFLOW_FLAG_BIT]) begin
                    state_next.input_overflow_flag = PSB_LO;
                end
            end else if (i_wb_adr == PSB_ADDR_DATA) begin
                state_next.out_latch = i_wb_dat[PSB_DW-1:0];
                if (state_reg.mode && !state_reg.rd_active) begin
                    state_next.output_full_flag = PSB_HI;
                end
            end else if (i_wb_adr == PSB_ADDR_FLAG) begin
                if (i_wb_dat[PSB_IRQ_BIT]) begin
                    state_next.irq_flag = PSB_LO;
                end
            end else if (i_wb_adr == PSB_ADDR_ENABLE) begin
                state_next.irq_en   = i_wb_dat[PSB_IRQ_BIT];
                state_next.irq_prio = i_wb_dat[PSB_PRIO_BIT];
            end
        end

        state_next.rdata = PSB_WORD_ZERO;
        if (wb_rd) begin
            if (i_wb_adr == PSB_ADDR_CTRL) begin
                state_next.rdata[PSB_IBF_BIT]  = state_reg.input_full_flag;
                state_next.rdata[PSB_OBF_BIT]  = state_reg.output_full_flag;
                state_next.rdata[PSB_INPUT_OVERFLOW_FLAG_BIT] = state_reg.input_overflow_flag;
                state_next.rdata[PSB_MODE_BIT] = state_reg.mode;
            end else if (i_wb_adr == PSB_ADDR_DATA) begin
                if (state_reg.mode) begin
                    state_next.rdata[PSB_DW-1:0] = state_reg.in_latch;
                    state_next.input_full_flag = PSB_LO;
                end else begin
                    state_next.rdata[PSB_DW-1:0] = state_reg.din_sync3;
                end
            end else if (i_wb_adr == PSB_ADDR_FLAG) begin
                state_next.rdata[PSB_IRQ_BIT] = state_reg.irq_flag;
            end else if (i_wb_adr == PSB_ADDR_ENABLE) begin
                state_next.rdata[PSB_IRQ_BIT]  = state_reg.irq_en;
                state_next.rdata[PSB_PRIO_BIT] = state_reg.irq_prio;
            end
        end

        // external strobe machine, dormant outside slave mode
        if (state_reg.mode) begin
            if (!state_reg.wr_active && !state_reg.rd_active) begin
                if (cs_low && wr_low) begin
                    state_next.wr_active = PSB_HI;
                end else if (cs_low && rd_low) begin
                    state_next.rd_active = PSB_HI;
                end
            end
            if (wr_end) begin
                state_next.wr_active = PSB_LO;
                state_next.in_latch  = state_reg.din_sync3;
                state_next.input_full_flag       = PSB_HI;
                state_next.irq_flag  = PSB_HI;
                if (state_reg.input_full_flag) begin
                    state_next.input_overflow_flag = PSB_HI;
                end
            end
            if (rd_end) begin
                state_next.rd_active = PSB_LO;
                state_next.output_full_flag       = PSB_LO;
                state_next.irq_flag  = PSB_HI;
            end
        end else begin
            state_next.wr_active = PSB_LO;
            state_next.rd_active = PSB_LO;
        end

        // pins follow the latch live so a cpu write shows at once
        state_next.pin_out  = state_next.out_latch;
        state_next.pin_oe_n = !(state_next.mode
            && state_next.rd_active);
        state_next.irq_out  = state_next.irq_flag && state_next.irq_en;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg           <= '0;
            state_reg.rd_sync   <= PSB_SYNC_IDLE;
            state_reg.wr_sync   <= PSB_SYNC_IDLE;
            state_reg.cs_sync   <= PSB_SYNC_IDLE;
            state_reg.pin_oe_n  <= PSB_HI;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        o_wb_dat            = state_reg.rdata;
        o_wb_ack            = state_reg.ack;
        o_byte_port_data    = state_reg.pin_out;
        o_byte_port_oe_n    = state_reg.pin_oe_n;
        o_slave_mode_select = state_reg.mode;
        o_irq               = state_reg.irq_out;
        o_irq_priority      = state_reg.irq_prio;
    end

    ////////////////////////////////////////////////////////////////////////
    a_write_sets_full: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && wr_end) |=> (state_reg.input_full_flag && state_reg.irq_flag))
        else $error("write end did not set full and irq");

    a_overflow_sets: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && wr_end && state_reg.input_full_flag) |=> state_reg.input_overflow_flag)
        else $error("overflow not flagged");

    a_overflow_sticky: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.input_overflow_flag && !wb_wr) |=> state_reg.input_overflow_flag)
        else $error("overflow dropped without software");

    a_read_drives: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && state_reg.rd_active && !rd_end
            && !(wb_wr && i_wb_adr == PSB_ADDR_CTRL))
            |=> !o_byte_port_oe_n)
        else $error("pins not driven during read");

    a_read_end_irq: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && rd_end)
            |=> (o_byte_port_oe_n && state_reg.irq_flag && !state_reg.output_full_flag))
        else $error("read end handling wrong");

    a_gpio_quiet: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        !state_reg.mode |=> o_byte_port_oe_n)
        else $error("pins driven outside slave mode");

    a_gpio_idle: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        !state_reg.mode |=> (!state_reg.wr_active && !state_reg.rd_active))
        else $error("strobe access taken outside slave mode");

    a_write_start: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && !state_reg.wr_active && !state_reg.rd_active
            && cs_low && wr_low) |=> state_reg.wr_active)
        else $error("write start not taken");

    a_cpu_write_full: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (wb_wr && i_wb_adr == PSB_ADDR_DATA && state_reg.mode
            && !state_reg.rd_active) |=> state_reg.output_full_flag)
        else $error("cpu data write left output full clear");

    a_end_waits_agree: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.mode && state_reg.wr_active && cs_low && !wr_high)
            |=> state_reg.wr_active)
        else $error("write ended before synchroniser agreed");

    a_no_obf_in_read: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (state_reg.rd_active && !state_reg.output_full_flag && !rd_end
            && !(wr_end && state_reg.mode)) |=> !state_reg.output_full_flag)
        else $error("output full set during read");

    a_cpu_read_clears: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (wb_rd && i_wb_adr == PSB_ADDR_DATA && state_reg.mode && !wr_end)
            |=> !state_reg.input_full_flag)
        else $error("cpu read left input full set");

    a_ctrl_low_zero: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (wb_rd && i_wb_adr == PSB_ADDR_CTRL)
            |=> (o_wb_dat[PSB_MODE_BIT-1:0] == '0))
        else $error("control low nibble not zero");

    a_bus_ack_once: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ---- verification/psb_host_model.sv ----
// external byte bus master: strobes and data for the slave port
// assumes the bench calls its tasks and resolves the shared data wire
`default_nettype none
module psb_host_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_pins,
    input  wire logic       i_oe_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_cs_n,
    output logic      [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_cs_n = 1'b1;
        o_data = 8'hA5;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic ext_write(input logic [7:0] b);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_wr_n <= 1'b0;
        o_data <= b;
        repeat (5) @(posedge i_mclk);
        o_wr_n <= 1'b1;
        o_cs_n <= 1'b1;
        repeat (5) @(posedge i_mclk);
        o_data <= ~b; // released bus must not keep the byte
        repeat (4) @(posedge i_mclk);
    endtask
    task automatic ext_read(input int hold, output logic [7:0] b,
                            output bit ok);
        int n;
        n = 0;
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        while (i_oe_n !== 1'b0 && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        repeat (hold) @(posedge i_mclk);
        b = i_pins;
        ok = (n < 20);
        o_rd_n <= 1'b1;
        o_cs_n <= 1'b1;
        repeat (8) @(posedge i_mclk);
        ok = ok && (i_oe_n === 1'b1);
    endtask
endmodule
`default_nettype wire

// ---- verification/psb_port_tb.sv ----
// self-checking bench of the parallel slave byte port
// assumes one 100 MHz clock; drives wishbone and the external bus model
`default_nettype none
module psb_port_tb;
    import psb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk, i_reset_n, cyc, stb, we, oe_n, irq, prio, mode, ack;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat;
    logic [7:0]  pins, dev_d, host_d, got, b1, b2;
    logic        rd_n, wr_n, cs_n;
    logic [31:0] exp_q[$];
    int          err_count, checks_done;
    int          seed = 32'h1B82;
    bit          ok;
    // device wins the wire only while it enables its drivers
    assign pins = (oe_n === 1'b0) ? dev_d : host_d;
    psb_port uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_read_strobe_pin_n(rd_n), .i_write_strobe_pin_n(wr_n),
        .i_chip_select_pin_n(cs_n), .i_byte_port_data(pins),
        .o_byte_port_data(dev_d), .o_byte_port_oe_n(oe_n),
        .o_slave_mode_select(mode), .o_irq(irq), .o_irq_priority(prio));
    psb_host_model host (.i_mclk(i_mclk), .i_pins(pins), .i_oe_n(oe_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_data(host_d));
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        sel  <= 4'hF;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        wb(1'b0, a, 8'h00);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        check({31'h0, irq}, {31'h0, lvl});
    endtask
    always @(posedge i_mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) check(rdat, 32'hDEAD_BEEF);
            else check(rdat, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #200us;
        err_count++;
        wrap_up();
    end
    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
        i_reset_n = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (3) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        rd(PSB_ADDR_CTRL, 8'h00);
        rd(PSB_ADDR_FLAG, 8'h00);
        rd(PSB_ADDR_ENABLE, 8'h00);
        rd(4'h2, 8'h00);
        host.ext_write(8'h3C);
        rd(PSB_ADDR_DATA, 8'hC3);
        rd(PSB_ADDR_CTRL, 8'h00);
        rd(PSB_ADDR_FLAG, 8'h00);
        wb(1'b1, PSB_ADDR_CTRL, 8'hFF);
        rd(PSB_ADDR_CTRL, 8'h10);
        check({31'h0, mode}, 32'h1);
        wb(1'b1, PSB_ADDR_ENABLE, 8'hC0);
        check({31'h0, prio}, 32'h1);
        b1 = 8'($random(seed));
        host.ext_write(b1);
        wait_irq(1'b1);
        rd(PSB_ADDR_CTRL, 8'h90);
        rd(PSB_ADDR_FLAG, 8'h80);
        rd(PSB_ADDR_DATA, b1);
        rd(PSB_ADDR_CTRL, 8'h10);
        wb(1'b1, PSB_ADDR_FLAG, 8'h80);
        wait_irq(1'b0);
        b2 = 8'($random(seed));
        host.ext_write(~b2);
        host.ext_write(b2);
        rd(PSB_ADDR_CTRL, 8'hB0);
        rd(PSB_ADDR_DATA, b2);
        wb(1'b1, PSB_ADDR_CTRL, 8'hF0);
        rd(PSB_ADDR_CTRL, 8'h30);
        wb(1'b1, PSB_ADDR_CTRL, 8'h10);
        rd(PSB_ADDR_CTRL, 8'h10);
        wb(1'b1, PSB_ADDR_FLAG, 8'h80);
        wb(1'b1, PSB_ADDR_DATA, 8'h5A);
        rd(PSB_ADDR_CTRL, 8'h50);
        wb(1'b1, PSB_ADDR_ENABLE, 8'h00);
        host.ext_read(2, got, ok);
        check({24'h0, got}, 32'h5A);
        check({31'h0, ok}, 32'h1);
        rd(PSB_ADDR_CTRL, 8'h10);
        rd(PSB_ADDR_FLAG, 8'h80);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, PSB_ADDR_FLAG, 8'h80);
        fork
            host.ext_read(12, got, ok);
            begin
                repeat (8) @(posedge i_mclk);
                wb(1'b1, PSB_ADDR_DATA, 8'hC3);
                rd(PSB_ADDR_CTRL, 8'h10);
            end
        join
        check({24'h0, got}, 32'hC3);
        rd(PSB_ADDR_CTRL, 8'h10);
        repeat (4) @(posedge i_mclk);
        check(exp_q.size(), 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
